//--- hdl/tkac_params.svh
/*
 * Constants of the touch-key acquisition controller: register offsets,
 * field positions, command codes, key counts and timing figures.
 * Assumes: included by the package and by the design modules.
 */
`ifndef TKAC_PARAMS_SVH
`define TKAC_PARAMS_SVH

// ==========================================================
// Keys and timing
`define TKAC_NKEY 11
`define TKAC_KEYS_ELEVEN 4'hb
`define TKAC_KEYS_SYNC 4'ha
`define TKAC_KEYS_SEVEN 4'h7
`define TKAC_CLK_HZ 20000000
`define TKAC_PERIOD_UNIT_MS 1
`define TKAC_TEST_PERIOD_S 10
`define TKAC_BURST_MAX 12'h800
`define TKAC_DI_MIN 8'h01

// ==========================================================
// Register byte offsets
`define TKAC_OFS_MODE 8'h00
`define TKAC_OFS_PERIOD 8'h04
`define TKAC_OFS_GUARD 8'h08
`define TKAC_OFS_MASK 8'h0c
`define TKAC_OFS_DI 8'h10
`define TKAC_OFS_THRESH 8'h14
`define TKAC_OFS_CMD 8'h18
`define TKAC_OFS_DETECT 8'h1c
`define TKAC_OFS_ERROR 8'h20
`define TKAC_OFS_STATUS 8'h24

// ==========================================================
// Field positions
`define TKAC_MODE_ELEVEN 0
`define TKAC_MODE_TIMED 1
`define TKAC_MODE_EDGE 4
`define TKAC_GUARD_EN 0

// ==========================================================
// Command codes
`define TKAC_CMD_SETUP 8'h01
`define TKAC_CMD_CAL_ALL 8'h03
`define TKAC_CMD_RESET 8'h04
`define TKAC_CMD_SLEEP 8'h05
`define TKAC_CMD_STORE 8'h0a
`define TKAC_CMD_RESTORE 8'h0b
`define TKAC_CMD_ERASE 8'h0c
`define TKAC_CMD_RECOVER 8'h0d
`define TKAC_CMD_KEY_HI 4'h1

`endif

//--- hdl/tkac_pkg.sv
/*
 * Types of the touch-key acquisition controller: states, command
 * operations and the state records of both modules.
 * Assumes: tkac_params.svh on the include path.
 */
`include "tkac_params.svh"

package tkac_pkg;

    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        TKAC_ACQ_IDLE = 2'b00,
        TKAC_ACQ_WAIT = 2'b01,
        TKAC_ACQ_REPORT = 2'b10
    } tkac_acq_t;

    typedef enum logic [3:0] {
        TKAC_OP_NONE = 4'h0,
        TKAC_OP_SETUP = 4'h1,
        TKAC_OP_CAL_ALL = 4'h2,
        TKAC_OP_RESET = 4'h3,
        TKAC_OP_SLEEP = 4'h4,
        TKAC_OP_STORE = 4'h5,
        TKAC_OP_RESTORE = 4'h6,
        TKAC_OP_ERASE = 4'h7,
        TKAC_OP_RECOVER = 4'h8,
        TKAC_OP_CAL_KEY = 4'h9
    } tkac_op_t;

    // ==========================================================
    // State records
    typedef struct packed {
        logic det;
        logic [7:0] cnt;
    } tkac_integ_st_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic sync_lvl;
        logic edge_pend;
        tkac_acq_t acq;
        logic [3:0] key;
        logic [31:0] cyc_cnt;
        logic overrun;
        logic [31:0] test_cnt;
        logic test_start;
        logic reset_req;
        logic eeprom_err;
        logic [7:0] mode;
        logic [15:0] period;
        logic guard_en;
        logic [3:0] guard_key;
        logic [`TKAC_NKEY-1:0] mask;
        logic [7:0] di;
        logic [11:0] thresh;
        logic [7:0] last_cmd;
        logic cmd_valid;
        tkac_op_t cmd_op;
        logic [3:0] cmd_key;
        logic meas_start;
        logic [3:0] meas_key;
        logic [`TKAC_NKEY-1:0][11:0] strength;
        logic [`TKAC_NKEY-1:0] key_err;
        logic [`TKAC_NKEY-1:0] detect;
        logic owner_vld;
        logic [3:0] owner;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tkac_st_t;

endpackage

//--- hdl/tkac_integ.sv
/*
 * Detection integrator of one key: counts consecutive acquisitions that
 * disagree with the current detect state and flips it at the limit.
 * Assumes: upd is a one-cycle pulse per measurement of this key.
 */
`timescale 1ns/10ps
`include "tkac_params.svh"

module tkac_integ (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Measurement result
    input wire logic upd,
    input wire logic over,
    input wire logic [7:0] limit,
    // Detect state
    output logic det
);

    // ==========================================================
    // State
    tkac_pkg::tkac_integ_st_t st;
    tkac_pkg::tkac_integ_st_t nx;
    logic [7:0] lim;

    assign lim = (limit == 8'h00) ? `TKAC_DI_MIN : limit;
    assign det = st.det;

    always_comb begin
        nx = st;
        if (upd) begin
            if (over != st.det) begin
                if (st.cnt + 8'h01 >= lim) begin
                    nx.det = over; // [RULE14] [RULE15]
                    nx.cnt = 8'h00;
                end else begin
                    nx.cnt = st.cnt + 8'h01;
                end
            end else begin
                nx.cnt = 8'h00;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_enter;
        (upd && over && !st.det && st.cnt == lim - 8'h01) |=> st.det;
    endproperty
    a_enter: assert property (p_enter) else $error("key did not enter detect"); // [RULE14]

    property p_leave_early;
        (st.det && upd && !over && st.cnt + 8'h01 < lim) |=> st.det;
    endproperty
    a_leave_early: assert property (p_leave_early) else $error("key left early"); // [RULE15]

endmodule

//--- hdl/tkac_acq_ctrl.sv
/*
 * Touch-key acquisition controller: trigger sequencing, sync input,
 * detect integration, single-winner suppression with guard key,
 * self-test scheduling and control command decode, over an APB slave.
 * Assumes: a measurement front end answers each meas_start with one
 * meas_done pulse; self-test and setup engines report on plain inputs.
 */
// Register access over APB and the register addresses were chosen for this implementation.
// Functional notes
// RULE1: Timed cycles start one period apart
// RULE2: Zero period runs cycles back to back
// RULE3: Sync mode uses key ten pin, ten keys
// RULE4: Bit 4 selects level or edge sync
// RULE5: Low sync runs cycles, high stops after
// RULE6: Host holds low sync at least 1 ms
// RULE7: One full cycle per sync rising edge
// RULE8: Guard key touch suppresses all other keys
// RULE9: Key already in detect blocks guard
// RULE10: Internal test failure resets the device
// RULE11: Memory and register test every 10 s
// RULE12: Functional failures flagged, operation continues
// RULE13: Range check per measurement, config on load
// RULE14: Key touched after limit of crossings
// RULE15: Key released after limit of non-crossings
// RULE16: Burst over 2048 pulses is an error
// RULE17: One masked key in detect at once
// RULE18: First masked key holds until released
// RULE19: Simultaneous masked keys, strongest wins
// RULE20: Commands act at once on receipt
// RULE21: Control codes 01,03,04,05,1k decoded
// RULE22: Nonvolatile codes 0A to 0D decoded
// RULE23: Mode bit selects eleven or seven keys
// RULE24: Sync input synchronised before use
`timescale 1ns/10ps
`include "tkac_params.svh"

module tkac_acq_ctrl #(
    parameter int unsigned MS_CYC = `TKAC_CLK_HZ / 1000 * `TKAC_PERIOD_UNIT_MS,
    parameter int unsigned TEST_CYC = `TKAC_TEST_PERIOD_S * `TKAC_CLK_HZ
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sync pin
    input wire logic key_ten_sense_pin,
    // Measurement front end
    output logic meas_start,
    output logic [3:0] meas_key,
    input wire logic meas_done,
    input wire logic [11:0] meas_count,
    input wire logic [11:0] meas_delta,
    // Commands
    output logic cmd_valid,
    output logic [3:0] cmd_op,
    output logic [3:0] cmd_key,
    // Self-test and setup load
    output logic test_start,
    input wire logic hw_test_fail,
    input wire logic code_crc_fail,
    input wire logic cfg_load_done,
    input wire logic cfg_load_ok,
    output logic sys_reset_req,
    // Detect outputs
    output logic [`TKAC_NKEY-1:0] key_detect
);

    // ==========================================================
    // State and decode
    tkac_pkg::tkac_st_t st;
    tkac_pkg::tkac_st_t nx;
    logic eleven, timed, edge_mode, range_bad, over;
    logic wr, rd, wr_cmd, sync_rise, go, keep, found, hit;
    logic [3:0] nkeys, best;
    logic [`TKAC_NKEY-1:0] key_en, raw, upd, grp;
    logic [11:0] bestv;
    logic [31:0] period_cyc, rdata;

    assign eleven = st.mode[`TKAC_MODE_ELEVEN];  // [RULE23]
    assign timed = !eleven || st.mode[`TKAC_MODE_TIMED];
    assign edge_mode = st.mode[`TKAC_MODE_EDGE];  // [RULE4]
    // Sync mode gives up key ten to the sync pin
    assign nkeys = !eleven ? `TKAC_KEYS_SEVEN :
                   (timed ? `TKAC_KEYS_ELEVEN : `TKAC_KEYS_SYNC);  // [RULE3] [RULE23]
    assign key_en = ~({`TKAC_NKEY{1'b1}} << nkeys);
    assign period_cyc = 32'(st.period) * MS_CYC;
    assign range_bad = (meas_count == 12'h000) || (meas_count > `TKAC_BURST_MAX);  // [RULE16]
    assign over = !range_bad && (meas_delta > st.thresh);  // [RULE14]
    assign grp = st.guard_en ? {`TKAC_NKEY{1'b1}} : st.mask;  // [RULE8] [RULE17]
    assign wr = psel && penable && pwrite && st.pready;
    assign rd = psel && penable && !pwrite && st.pready;
    assign wr_cmd = wr && (paddr == `TKAC_OFS_CMD);
    assign sync_rise = !st.sync_lvl && (st.s2 == st.s3) && st.s3;

    // ==========================================================
    // Per-key integrators
    for (genvar g = 0; g < `TKAC_NKEY; g++) begin : g_key
        assign upd[g] = (st.acq == tkac_pkg::TKAC_ACQ_WAIT) && meas_done && (st.key == 4'(g));
        tkac_integ u_integ (
            .pclk(pclk),
            .presetn(presetn),
            .upd(upd[g]),
            .over(over),
            .limit(st.di),
            .det(raw[g])
        );
    end

    // ==========================================================
    // Command decode
    function automatic tkac_pkg::tkac_op_t decode(input logic [7:0] b);
        case (b)
            `TKAC_CMD_SETUP: decode = tkac_pkg::TKAC_OP_SETUP;
            `TKAC_CMD_CAL_ALL: decode = tkac_pkg::TKAC_OP_CAL_ALL;
            `TKAC_CMD_RESET: decode = tkac_pkg::TKAC_OP_RESET;
            `TKAC_CMD_SLEEP: decode = tkac_pkg::TKAC_OP_SLEEP;
            `TKAC_CMD_STORE: decode = tkac_pkg::TKAC_OP_STORE;
            `TKAC_CMD_RESTORE: decode = tkac_pkg::TKAC_OP_RESTORE;
            `TKAC_CMD_ERASE: decode = tkac_pkg::TKAC_OP_ERASE;
            `TKAC_CMD_RECOVER: decode = tkac_pkg::TKAC_OP_RECOVER;
            default: decode = (b[7:4] == `TKAC_CMD_KEY_HI && b[3:0] < `TKAC_KEYS_ELEVEN)
                              ? tkac_pkg::TKAC_OP_CAL_KEY : tkac_pkg::TKAC_OP_NONE;
        endcase
    endfunction

    // ==========================================================
    // Register read mux
    always_comb begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `TKAC_OFS_MODE: rdata[7:0] = st.mode;
            `TKAC_OFS_PERIOD: rdata[15:0] = st.period;
            `TKAC_OFS_GUARD: rdata[7:0] = {st.guard_key, 3'h0, st.guard_en};
            `TKAC_OFS_MASK: rdata[`TKAC_NKEY-1:0] = st.mask;
            `TKAC_OFS_DI: rdata[7:0] = st.di;
            `TKAC_OFS_THRESH: rdata[11:0] = st.thresh;
            `TKAC_OFS_CMD: rdata[7:0] = st.last_cmd;
            `TKAC_OFS_DETECT: rdata[`TKAC_NKEY-1:0] = st.detect;
            `TKAC_OFS_ERROR: rdata[`TKAC_NKEY-1:0] = st.key_err;  // [RULE12]
            `TKAC_OFS_STATUS: rdata[4:0] = {st.reset_req, st.sync_lvl, st.eeprom_err,
                                            st.overrun, st.acq != tkac_pkg::TKAC_ACQ_IDLE};
            default: hit = 1'b0;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        nx = st;
        go = 1'b0;
        keep = 1'b0;
        found = 1'b0;
        best = 4'h0;
        bestv = 12'h000;
        nx.meas_start = 1'b0;
        nx.cmd_valid = 1'b0;
        nx.test_start = 1'b0;
        // Sync pin: three flops, level accepted when second and third agree
        nx.s1 = key_ten_sense_pin;  // [RULE24]
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        if (st.s2 == st.s3) begin
            nx.sync_lvl = st.s3;  // [RULE24]
        end
        // APB: zero wait states, data caught in setup
        nx.pready = psel && !penable;
        if (psel && !penable) begin
            nx.prdata = rdata;
            nx.pslverr = !hit;
        end
        if (wr) begin
            case (paddr)
                `TKAC_OFS_MODE: nx.mode = pwdata[7:0];
                `TKAC_OFS_PERIOD: nx.period = pwdata[15:0];
                `TKAC_OFS_GUARD: begin
                    nx.guard_en = pwdata[`TKAC_GUARD_EN];
                    nx.guard_key = pwdata[7:4];
                end
                `TKAC_OFS_MASK: nx.mask = pwdata[`TKAC_NKEY-1:0];
                `TKAC_OFS_DI: nx.di = pwdata[7:0];
                `TKAC_OFS_THRESH: nx.thresh = pwdata[11:0];
                `TKAC_OFS_CMD: begin
                    nx.last_cmd = pwdata[7:0];
                    nx.cmd_valid = 1'b1;  // [RULE20]
                    nx.cmd_op = decode(pwdata[7:0]);  // [RULE21] [RULE22]
                    nx.cmd_key = pwdata[3:0];
                end
                default: nx.mode = st.mode;
            endcase
        end
        if (rd && paddr == `TKAC_OFS_STATUS) begin
            nx.overrun = 1'b0;
        end
        // Cycle timer measured from each cycle start
        if (st.cyc_cnt != 32'hffff_ffff) begin
            nx.cyc_cnt = st.cyc_cnt + 32'h0000_0001;
        end
        if (timed && st.period != 16'h0000 && st.acq != tkac_pkg::TKAC_ACQ_IDLE
            && st.cyc_cnt == period_cyc) begin
            nx.overrun = 1'b1;
        end
        // Acquisition sequencer
        unique case (st.acq)
            tkac_pkg::TKAC_ACQ_IDLE: begin
                if (timed) begin
                    go = (st.period == 16'h0000) || (st.cyc_cnt >= period_cyc);  // [RULE1] [RULE2]
                end else if (edge_mode) begin
                    go = st.edge_pend;  // [RULE7]
                end else begin
                    go = !st.sync_lvl;  // [RULE5]
                end
                if (go) begin
                    nx.acq = tkac_pkg::TKAC_ACQ_WAIT;
                    nx.key = 4'h0;
                    nx.meas_key = 4'h0;
                    nx.meas_start = 1'b1;
                    nx.cyc_cnt = 32'h0000_0001;  // [RULE1]
                    nx.edge_pend = 1'b0;
                end
            end
            tkac_pkg::TKAC_ACQ_WAIT: begin
                if (meas_done) begin
                    if (st.key < `TKAC_KEYS_ELEVEN) begin
                        nx.strength[st.key] = over ? meas_delta : 12'h000;
                        nx.key_err[st.key] = range_bad;  // [RULE13] [RULE16]
                    end
                    if (st.key >= nkeys - 4'h1) begin
                        nx.acq = tkac_pkg::TKAC_ACQ_REPORT;
                    end else begin
                        nx.key = st.key + 4'h1;
                        nx.meas_key = st.key + 4'h1;
                        nx.meas_start = 1'b1;
                    end
                end
            end
            tkac_pkg::TKAC_ACQ_REPORT: begin
                // Current owner holds while still touched
                keep = st.owner_vld && raw[st.owner] && grp[st.owner] && key_en[st.owner];  // [RULE18] [RULE9]
                for (int i = 0; i < `TKAC_NKEY; i++) begin
                    if (raw[i] && grp[i] && key_en[i] && (!found || st.strength[i] > bestv)) begin
                        found = 1'b1;  // [RULE19]
                        best = 4'(i);
                        bestv = st.strength[i];
                    end
                end
                if (st.guard_en && st.guard_key < nkeys && raw[st.guard_key]) begin
                    best = st.guard_key;  // [RULE8]
                end
                nx.owner_vld = keep || found;
                nx.owner = keep ? st.owner : best;  // [RULE18]
                nx.detect = (raw & key_en & ~grp)
                          | (nx.owner_vld ? ({{(`TKAC_NKEY-1){1'b0}}, 1'b1} << nx.owner)
                                          : {`TKAC_NKEY{1'b0}});  // [RULE17]
                nx.acq = tkac_pkg::TKAC_ACQ_IDLE;
            end
            default: nx.acq = tkac_pkg::TKAC_ACQ_IDLE;
        endcase

        // Edge seen during a cycle is kept for the next one; set wins
        if (edge_mode && sync_rise) begin
            nx.edge_pend = 1'b1;  // [RULE7]
        end

        // Periodic memory and register test
        if (st.test_cnt >= TEST_CYC - 1) begin
            nx.test_cnt = 32'h0000_0000;
            nx.test_start = 1'b1;  // [RULE11]
        end else begin
            nx.test_cnt = st.test_cnt + 32'h0000_0001;
        end
        if (hw_test_fail || code_crc_fail) begin
            nx.reset_req = 1'b1;  // [RULE10]
        end
        if (cfg_load_done) begin
            nx.eeprom_err = !cfg_load_ok;  // [RULE13] [RULE12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign meas_start = st.meas_start;
    assign meas_key = st.meas_key;
    assign cmd_valid = st.cmd_valid;
    assign cmd_op = st.cmd_op;
    assign cmd_key = st.cmd_key;
    assign test_start = st.test_start;
    assign sys_reset_req = st.reset_req;
    assign key_detect = st.detect;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_period;
        (st.acq == tkac_pkg::TKAC_ACQ_IDLE && timed && st.period != 16'h0000
         && st.cyc_cnt < period_cyc) |=> !st.meas_start;
    endproperty
    a_period: assert property (p_period) else $error("cycle started early"); // [RULE1]
    property p_free_run;
        (st.acq == tkac_pkg::TKAC_ACQ_IDLE && timed && st.period == 16'h0000)
        |=> st.meas_start;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run stalled"); // [RULE2]
    property p_sync_hold;
        (st.acq == tkac_pkg::TKAC_ACQ_IDLE && !timed && !edge_mode && st.sync_lvl)
        |=> !st.meas_start;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("measured with sync high"); // [RULE5]
    property p_sync_edge;
        (st.acq == tkac_pkg::TKAC_ACQ_IDLE && !timed && edge_mode && sync_rise
         && !st.edge_pend) |-> ##2 st.meas_start && st.meas_key == 4'h0;
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("edge did not start cycle"); // [RULE7]
    property p_one_winner;
        (st.acq == tkac_pkg::TKAC_ACQ_REPORT) |=> $onehot0(st.detect & $past(grp));
    endproperty
    a_one_winner: assert property (p_one_winner) else $error("two masked keys in detect"); // [RULE17]
    property p_keep_owner;
        (st.acq == tkac_pkg::TKAC_ACQ_REPORT && keep)
        |=> st.owner == $past(st.owner) && st.detect[st.owner];
    endproperty
    a_keep_owner: assert property (p_keep_owner) else $error("owner key displaced"); // [RULE18]
    property p_reset_req;
        (hw_test_fail || code_crc_fail) |=> st.reset_req;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("no reset on test failure"); // [RULE10]
    property p_selftest;
        (st.test_cnt == TEST_CYC - 1) |=> st.test_start ##1 !st.test_start;
    endproperty
    a_selftest: assert property (p_selftest) else $error("self-test not started"); // [RULE11]
    property p_range;
        (st.acq == tkac_pkg::TKAC_ACQ_WAIT && meas_done && meas_count > `TKAC_BURST_MAX
         && st.key < `TKAC_KEYS_ELEVEN) |=> st.key_err[$past(st.key)];
    endproperty
    a_range: assert property (p_range) else $error("range error not flagged"); // [RULE13]
    property p_cmd_now;
        wr_cmd |=> st.cmd_valid ##1 !st.cmd_valid;
    endproperty
    a_cmd_now: assert property (p_cmd_now) else $error("command not issued at once"); // [RULE20]
    property p_cmd_reset;
        (wr_cmd && pwdata[7:0] == `TKAC_CMD_RESET)
        |=> st.cmd_valid && st.cmd_op == tkac_pkg::TKAC_OP_RESET;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset) else $error("reset code misdecoded"); // [RULE21]
    property p_cmd_erase;
        (wr_cmd && pwdata[7:0] == `TKAC_CMD_ERASE)
        |=> st.cmd_valid && st.cmd_op == tkac_pkg::TKAC_OP_ERASE;
    endproperty
    a_cmd_erase: assert property (p_cmd_erase) else $error("erase code misdecoded"); // [RULE22]

endmodule

//--- test/tkac_front_model.sv
/* Measurement front-end model: one done pulse per start.
 * Assumes: same clock as the controller. */
`timescale 1ns/10ps
module tkac_front_model (
    // Clock
    input wire logic pclk,
    // Requests and answers
    input wire logic meas_start,
    input wire logic [3:0] meas_key,
    input wire logic [10:0][11:0] tab,
    output logic meas_done = 1'b0,
    output logic [11:0] meas_count = 12'h000,
    output logic [11:0] meas_delta = 12'h000
);
    // ==========================================================
    // Answer after a random delay
    int w = -1;
    logic [3:0] k = 4'h0;
    always @(posedge pclk) begin
        meas_done <= 1'b0;
        meas_count <= ~meas_count;
        meas_delta <= ~meas_delta;
        if (w == 0) begin
            meas_done <= 1'b1;
            meas_count <= (tab[k] == 12'hfff) ? 12'hfff : 12'h064;
            meas_delta <= tab[k];
        end
        if (w >= 0) w <= w - 1;
        if (meas_start) begin
            w <= int'($urandom % 3);
            k <= meas_key;
        end
    end
endmodule

//--- test/touch_key_acquisition_control_tb.sv
/* Bench: APB master, sync pin, front-end model, reference integrator.
 * Assumes: design assertions run alongside. */
`timescale 1ns/10ps
module touch_key_acquisition_control_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, pin = 1'b1, fin = 1'b0, ms, md, cv, ts, rq;
    logic [3:0] mk, op, ck;
    logic [11:0] mc, mdl;
    logic [10:0] det, m_det = 11'h000;
    logic [10:0][11:0] tab = '0;
    logic [7:0] cd[10] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h1a, 8'h07};
    logic [3:0] ops[10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0};
    int n_fail = 0, num_checks = 0, di_m = 1, th_m = 0, cnt[11], n, n_st = 0, k0;
    bit cmp_on = 1;
    always #25 pclk = ~pclk;
    tkac_acq_ctrl #(.MS_CYC(20), .TEST_CYC(64)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_ten_sense_pin(pin),
        .meas_start(ms), .meas_key(mk), .meas_done(md), .meas_count(mc), .meas_delta(mdl),
        .cmd_valid(cv), .cmd_op(op), .cmd_key(ck), .test_start(ts), .hw_test_fail(fin),
        .code_crc_fail(1'b0), .cfg_load_done(fin), .cfg_load_ok(1'b0),
        .sys_reset_req(rq), .key_detect(det));
    tkac_front_model fm_u (.pclk(pclk), .meas_start(ms), .meas_key(mk), .tab(tab),
        .meas_done(md), .meas_count(mc), .meas_delta(mdl));
    // ==========================================================
    // Reference integrator, compared at each cycle start while cmp_on is set
    always @(posedge pclk) begin
        n_st += ms;
        if (md) begin
            if ((int'(mdl) > th_m) != m_det[mk]) cnt[mk]++;
            else cnt[mk] = 0;
            if (cnt[mk] >= di_m) begin
                m_det[mk] = !m_det[mk];
                cnt[mk] = 0;
            end
        end
    end
    always @(negedge pclk) if (ms && mk == 4'h0 && cmp_on) check(det, m_det);
    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
        if (i == 20) begin n_fail++; wrap_up; end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic bit hit(bit t);
        return t ? ts : (ms && mk == 4'h0);
    endfunction
    task automatic gap(input bit t, output int g);
        int i = 0;
        while (!hit(t) && i < 900) begin @(posedge pclk); i++; end
        g = 0;
        do begin @(posedge pclk); g++; end while (!hit(t) && g < 900);
        if (g >= 900) begin n_fail++; wrap_up; end
    endtask
    task automatic run(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h4464));
        run(4);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        check(er, 1'b1);
        apb(1'b1, 8'h10, 32'h3);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h3);
        di_m = 3;
        apb(1'b1, 8'h14, 32'h20);
        th_m = 32;
        tab[2] <= 12'h021 + 12'($urandom % 200);
        run(300);
        check(det[2], 1'b1);
        tab[2] <= 12'h000;
        run(300);
        check(det[2], 1'b0);
        cmp_on = 0;
        apb(1'b1, 8'h0c, 32'h7f);
        tab[1] <= 12'h040;
        tab[3] <= 12'h060;
        run(300);
        check(det, 11'h008);
        tab[5] <= 12'h0f0;
        run(300);
        check(det, 11'h008);
        tab[3] <= 12'h000;
        run(300);
        check(det, 11'h020);
        apb(1'b1, 8'h08, 32'h41);
        tab[4] <= 12'h030;
        run(300);
        check(det, 11'h020);
        tab[5] <= 12'h000;
        run(300);
        check(det, 11'h010);
        apb(1'b1, 8'h04, 32'h3);
        apb(1'b1, 8'h00, 32'h3);
        gap(1'b0, n);
        gap(1'b0, n);
        check(n, 60);
        apb(1'b1, 8'h00, 32'h11);
        pin <= 1'b0;
        run(100);
        k0 = n_st;
        pin <= 1'b1;
        run(4);
        pin <= 1'b0;
        run(4);
        pin <= 1'b1;
        run(300);
        check(n_st - k0, 20);
        apb(1'b1, 8'h00, 32'h1);
        run(100);
        k0 = n_st;
        run(100);
        check(n_st - k0, 0);
        pin <= 1'b0;
        tab[6] <= 12'hfff;
        run(100);
        check(n_st > k0, 1'b1);
        gap(1'b1, n);
        check(n, 64);
        check(rq, 1'b0);
        fin <= 1'b1;
        run(1);
        fin <= 1'b0;
        run(4);
        check(rq, 1'b1);
        apb(1'b0, 8'h24, 32'h0);
        check(rd[4:2], 3'b101);
        apb(1'b0, 8'h20, 32'h0);
        check(rd[6], 1'b1);
        foreach (cd[i]) begin
            apb(1'b1, 8'h18, {24'h0, cd[i]});
            run(1);
            check({cv, op, ck}, {1'b1, ops[i], cd[i][3:0]});
        end
        wrap_up;
    end
endmodule
